// file: design/odsc_top.sv
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// channel seven divider and status pin clock routing
module odsc_top
   import odsc_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [9:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic [1:0] chSourceSel,
   input wire logic synthOneTick,
   input wire logic synthTwoTick,
   input wire logic refTick,
   input wire logic [ODSC_DATA_W-1:0] cmosDivACode,
   input wire logic [ODSC_DATA_W-1:0] cmosDivBCode,
   input wire logic [1:0] statusIn,
   output logic ch7Tick,
   output logic [1:0] statPin,
   output logic [1:0] statPinOe
);
   // ==========================================================
   // register bus slave: one wait state on every access
   logic ack_reg;
   logic [ODSC_DATA_W-1:0] ch7Div_reg;
   logic [ODSC_DATA_W-1:0] route_reg;
   logic [31:0] readdata_reg;
   logic clkA_reg;
   logic clkB_reg;
   logic [1:0] statPin_reg;
   logic [1:0] statPinOe_reg;

   wire request = read || write;
   wire accept = request && ack_reg;
   wire wrLow = write && accept && byteenable[0];
   wire hitCh7 = (address == CH7_DIV_ADDR);
   wire hitRoute = (address == ROUTE_ADDR);
   wire hitState = (address == STATE_ADDR);
   wire [ODSC_DATA_W-1:0] stateView = {4'h0, statPin_reg, clkB_reg, clkA_reg};
   // unmapped reads return zero, unmapped writes vanish
   wire [ODSC_DATA_W-1:0] readSel = hitCh7 ? ch7Div_reg :
                                    hitRoute ? route_reg :
                                    hitState ? stateView : '0;
   assign waitrequest = request && !ack_reg;
   assign readdata = readdata_reg;

   // bus handshake and read capture
   always_ff @(posedge clk) begin
      if (reset) begin
         ack_reg <= 1'b0;
         readdata_reg <= '0;
      end else begin
         ack_reg <= request && !ack_reg;
         if (request && !ack_reg) begin
            readdata_reg <= {24'h00_0000, readSel};
         end
      end
   end

   // configuration registers
   always_ff @(posedge clk) begin
      if (reset) begin
         ch7Div_reg <= CH7_DIV_RST;
         route_reg <= ROUTE_RST;
      end else begin
         if (wrLow && hitCh7) begin
            ch7Div_reg <= writedata[ODSC_DATA_W-1:0];
         end
         if (wrLow && hitRoute) begin
            route_reg <= writedata[ODSC_DATA_W-1:0];
         end
      end
   end

   // ==========================================================
   // field decode
   wire [1:0] syn2Pre = route_reg[SYN2_PRE_LSB +: SEL_W];
   wire [1:0] syn1Pre = route_reg[SYN1_PRE_LSB +: SEL_W];
   wire [1:0] pinSel [2];
   assign pinSel[1] = route_reg[PIN1_SEL_LSB +: SEL_W];
   assign pinSel[0] = route_reg[PIN0_SEL_LSB +: SEL_W];
   wire srcSynth = (chSourceSel == SRC_SYN1) || (chSourceSel == SRC_SYN2);

   odsc_div_if chDiv();
   odsc_div_if preOne();
   odsc_div_if preTwo();
   odsc_div_if divA();
   odsc_div_if divB();

   // channel seven: references pass straight through
   assign chDiv.tickIn = (chSourceSel == SRC_SYN1) ? synthOneTick :
                         (chSourceSel == SRC_SYN2) ? synthTwoTick : refTick;
   assign chDiv.enable = 1'b1;
   assign chDiv.bypass = !srcSynth || (ch7Div_reg == DIV_OFF_CODE);
   assign chDiv.code = ch7Div_reg;
   assign ch7Tick = chDiv.tickOut;

   // pre-dividers; reserved code 3 is treated as off
   assign preOne.tickIn = synthOneTick;
   assign preOne.enable = (syn1Pre == PRE_DIV4) || (syn1Pre == PRE_DIV5);
   assign preOne.bypass = 1'b0;
   assign preOne.code = (syn1Pre == PRE_DIV4) ? PRE4_CODE : PRE5_CODE;
   assign preTwo.tickIn = synthTwoTick;
   assign preTwo.enable = (syn2Pre == PRE_DIV4) || (syn2Pre == PRE_DIV5);
   assign preTwo.bypass = 1'b0;
   assign preTwo.code = (syn2Pre == PRE_DIV4) ? PRE4_CODE : PRE5_CODE;

   // cmos dividers: a from synthesizer one, b from synthesizer two
   assign divA.tickIn = preOne.tickOut;
   assign divA.enable = (cmosDivACode != DIV_OFF_CODE);
   assign divA.bypass = 1'b0;
   assign divA.code = cmosDivACode;
   assign divB.tickIn = preTwo.tickOut;
   assign divB.enable = (cmosDivBCode != DIV_OFF_CODE);
   assign divB.bypass = 1'b0;
   assign divB.code = cmosDivBCode;

   odsc_tick_div uChDiv (.clk(clk), .reset(reset), .p(chDiv));
   odsc_tick_div uPreOne (.clk(clk), .reset(reset), .p(preOne));
   odsc_tick_div uPreTwo (.clk(clk), .reset(reset), .p(preTwo));
   odsc_tick_div uDivA (.clk(clk), .reset(reset), .p(divA));
   odsc_tick_div uDivB (.clk(clk), .reset(reset), .p(divB));

   // square waves: one toggle per divided tick, halves the rate
   always_ff @(posedge clk) begin
      if (reset) begin
         clkA_reg <= 1'b0;
         clkB_reg <= 1'b0;
      end else begin
         clkA_reg <= clkA_reg ^ divA.tickOut;
         clkB_reg <= clkB_reg ^ divB.tickOut;
      end
   end

   // ==========================================================
   // status pin muxes
   genvar i;
   generate
      for (i = 0; i < 2; i++) begin : gPin
         wire pinOut = (pinSel[i] == PIN_DIV_A) ? clkA_reg :
                       (pinSel[i] == PIN_DIV_B) ? clkB_reg :
                       (pinSel[i] == PIN_STATUS) ? statusIn[i] : 1'b0;
         wire pinOe = (pinSel[i] != PIN_OFF);

         // registered so a mux change cannot glitch the pin
         always_ff @(posedge clk) begin
            if (reset) begin
               statPin_reg[i] <= 1'b0;
               statPinOe_reg[i] <= 1'b0;
            end else begin
               statPin_reg[i] <= pinOut;
               statPinOe_reg[i] <= pinOe;
            end
         end

         a_pin_off_static: assert property (@(posedge clk) disable iff (reset)
            pinSel[i] == PIN_OFF |=> !statPin[i] && !statPinOe[i])
            else $error("disabled status pin not static");
         a_pin_status_path: assert property (@(posedge clk) disable iff (reset)
            pinSel[i] == PIN_STATUS |=> statPin[i] == $past(statusIn[i]) && statPinOe[i])
            else $error("status level not routed to pin");
         a_pin_clock_src: assert property (@(posedge clk) disable iff (reset)
            pinSel[i] == PIN_DIV_B |=> statPin[i] == $past(clkB_reg))
            else $error("pin not following cmos_div_b clock");
         a_pin_diva_src: assert property (@(posedge clk) disable iff (reset)
            pinSel[i] == PIN_DIV_A |=> statPin[i] == $past(clkA_reg) && statPinOe[i])
            else $error("pin not following cmos_div_a clock");
      end
   endgenerate
   assign statPin = statPin_reg;
   assign statPinOe = statPinOe_reg;

   // ==========================================================
   // checks
   a_ch7_write_takes: assert property (@(posedge clk) disable iff (reset)
      wrLow && hitCh7 |=> ch7Div_reg == $past(writedata[7:0]))
      else $error("divider write lost");
   a_route_reset_val: assert property (@(posedge clk)
      reset |=> route_reg == ROUTE_RST)
      else $error("route register reset value wrong");
   a_ch7_bypass_code: assert property (@(posedge clk) disable iff (reset)
      ch7Div_reg == DIV_OFF_CODE && chSourceSel == SRC_SYN1 && synthOneTick |=> ch7Tick)
      else $error("code zero did not bypass");
   a_ch7_half_rate: assert property (@(posedge clk) disable iff (reset)
      (ch7Div_reg == 8'h01 && srcSynth && ch7Tick) ##1 (ch7Div_reg == 8'h01 && srcSynth)
      |-> !ch7Tick)
      else $error("divide by two produced adjacent ticks");
   a_ch7_ref_pass: assert property (@(posedge clk) disable iff (reset)
      !srcSynth && refTick |=> ch7Tick)
      else $error("reference not passed undivided");
   a_pre_off_quiet: assert property (@(posedge clk) disable iff (reset)
      syn1Pre == PRE_OFF |=> !preOne.tickOut)
      else $error("disabled pre-divider ticked");
   a_diva_off_quiet: assert property (@(posedge clk) disable iff (reset)
      cmosDivACode == DIV_OFF_CODE |=> !divA.tickOut)
      else $error("cmos_div_a ticked with code zero");
   a_diva_from_pre: assert property (@(posedge clk) disable iff (reset)
      divA.tickOut |-> $past(preOne.tickOut))
      else $error("cmos_div_a tick without pre-divider tick");
   a_bus_one_wait: assert property (@(posedge clk) disable iff (reset)
      $rose(read) |-> waitrequest ##1 !waitrequest)
      else $error("read not answered after one wait");
   a_bus_write_wait: assert property (@(posedge clk) disable iff (reset)
      $rose(write) |-> waitrequest ##1 !waitrequest)
      else $error("write not answered after one wait");
   a_divb_from_pre: assert property (@(posedge clk) disable iff (reset)
      divB.tickOut |-> $past(preTwo.tickOut))
      else $error("cmos_div_b tick without pre-divider tick");

   c_ch7_divided: cover property (@(posedge clk) ch7Tick && ch7Div_reg > 8'h01 && srcSynth);
   c_pin_toggles: cover property (@(posedge clk) pinSel[0] == PIN_DIV_A && $rose(statPin[0]));
   c_route_write: cover property (@(posedge clk) wrLow && hitRoute);
   c_pin_disabled: cover property (@(posedge clk) pinSel[0] == PIN_OFF && pinSel[1] == PIN_STATUS);
   c_ch7_bypass: cover property (@(posedge clk) ch7Tick && ch7Div_reg == DIV_OFF_CODE && srcSynth);
endmodule // odsc_top
`default_nettype wire

// file: design/odsc_pkg.sv
package odsc_pkg;
   // ==========================================================
   // register map (register offsets are word indices)
   localparam int ODSC_DATA_W = 8;
   localparam logic [7:0] CH7_DIV_IDX = 8'h2c;
   localparam logic [7:0] ROUTE_IDX = 8'h2d;
   localparam logic [7:0] STATE_IDX = 8'h30;
   localparam logic [9:0] CH7_DIV_ADDR = {CH7_DIV_IDX, 2'b00};
   localparam logic [9:0] ROUTE_ADDR = {ROUTE_IDX, 2'b00};
   localparam logic [9:0] STATE_ADDR = {STATE_IDX, 2'b00};
   localparam logic [7:0] CH7_DIV_RST = 8'h05;
   localparam logic [7:0] ROUTE_RST = 8'h0a;
   // ==========================================================
   // field positions
   localparam int SYN2_PRE_LSB = 6;
   localparam int SYN1_PRE_LSB = 4;
   localparam int PIN1_SEL_LSB = 2;
   localparam int PIN0_SEL_LSB = 0;
   localparam int SEL_W = 2;
   // ==========================================================
   // encodings
   localparam logic [1:0] PRE_OFF = 2'h0;
   localparam logic [1:0] PRE_DIV4 = 2'h1;
   localparam logic [1:0] PRE_DIV5 = 2'h2;
   localparam logic [7:0] PRE4_CODE = 8'h03;
   localparam logic [7:0] PRE5_CODE = 8'h04;
   localparam logic [1:0] PIN_DIV_A = 2'h0;
   localparam logic [1:0] PIN_DIV_B = 2'h1;
   localparam logic [1:0] PIN_STATUS = 2'h2;
   localparam logic [1:0] PIN_OFF = 2'h3;
   localparam logic [1:0] SRC_SYN1 = 2'h0;
   localparam logic [1:0] SRC_SYN2 = 2'h1;
   localparam logic [7:0] DIV_OFF_CODE = 8'h00;
endpackage

// file: design/odsc_div_if.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// one tick divider: control side and divider side
interface odsc_div_if;
   import odsc_pkg::*;
   logic tickIn;
   logic enable;
   logic bypass;
   logic [ODSC_DATA_W-1:0] code;
   logic tickOut;
   modport ctrl(output tickIn, output enable, output bypass, output code, input tickOut);
   modport div(input tickIn, input enable, input bypass, input code, output tickOut);
endinterface // odsc_div_if
`default_nettype wire

// file: design/odsc_tick_div.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// divide a tick stream by code+1, or pass it when bypassed
module odsc_tick_div
   import odsc_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   odsc_div_if.div p
);
   logic [ODSC_DATA_W-1:0] cnt_reg;
   logic [ODSC_DATA_W-1:0] cnt_next;
   logic out_reg;
   logic out_next;
   wire atTerm = (cnt_reg == p.code);
   wire idle = !p.enable || p.bypass;

   // counter wraps past 255 if code is lowered under it, so a
   // reprogram costs at most one long period, never a lockup
   assign cnt_next = idle ? '0 :
                     (p.tickIn ? (atTerm ? '0 : cnt_reg + 8'h01) : cnt_reg);
   assign out_next = p.enable && p.tickIn && (p.bypass || atTerm);
   assign p.tickOut = out_reg;

   // registered so every path has the same one-cycle latency
   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_reg <= '0;
         out_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         out_reg <= out_next;
      end
   end
endmodule // odsc_tick_div
`default_nettype wire

// file: bench/odsc_pin_mon.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// downstream receiver: times the edges seen on one status pin
module odsc_pin_mon (
   input wire logic clk,
   input wire logic pin,
   input wire logic oe,
   output var int halfPer,
   output var int edges
);
   logic lastLvl = 1'b0;
   int since = 0;
   int hp = 0;
   int ne = 0;
   // an undriven pin reads as idle low, so it can never fake an edge
   always @(posedge clk) begin
      lastLvl <= pin & oe;
      if ((pin & oe) !== lastLvl) begin
         hp <= since;
         ne <= ne + 1;
         since <= 1;
      end else begin
         since <= since + 1;
      end
   end
   assign halfPer = hp;
   assign edges = ne;
endmodule // odsc_pin_mon
`default_nettype wire

// file: bench/tb_odsc_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_odsc_top;
   import odsc_pkg::*;
   logic clk, reset, read, write, ch7Tick;
   logic [9:0] address;
   logic [31:0] writedata, readdata, rd;
   logic [3:0] byteenable;
   logic waitrequest;
   logic [1:0] chSourceSel, statusIn, statPin, statPinOe, p1, p2, s0;
   logic [2:0] tickEn;
   logic slow;
   logic [7:0] ca, cb, code;
   int failures = 0;
   int n_compared = 0;
   int g, hp0, hp1, e0, e1;
   odsc_top dut (.clk(clk), .reset(reset), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .chSourceSel(chSourceSel), .synthOneTick(tickEn[0]),
      .synthTwoTick(tickEn[1]), .refTick(tickEn[2]), .cmosDivACode(ca), .cmosDivBCode(cb),
      .statusIn(statusIn), .ch7Tick(ch7Tick), .statPin(statPin), .statPinOe(statPinOe));
   odsc_pin_mon mon0 (.clk(clk), .pin(statPin[0]), .oe(statPinOe[0]), .halfPer(hp0), .edges(e0));
   odsc_pin_mon mon1 (.clk(clk), .pin(statPin[1]), .oe(statPinOe[1]), .halfPer(hp1), .edges(e1));
   // ==========================================================
   // clock and watchdog
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // source ticks: every cycle, or every other cycle while slow is set
   always @(posedge clk) tickEn <= slow ? ~tickEn : 3'h7;
   initial begin
      #400000;
      failures++;
      summarize();
   end
   // ==========================================================
   // expectations
   function automatic int ch7_exp(logic [1:0] s, logic [7:0] c);
      return (s < 2'h2 && c != 8'h00) ? int'(c) + 1 : 1;
   endfunction
   function automatic int half_exp(logic [1:0] p, logic [7:0] c);
      return (p == 2'h1 ? 4 : 5) * (int'(c) + 1);
   endfunction
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("compared %0d mismatched %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ==========================================================
   // bus master: hold request until waitrequest is seen low at an edge
   task automatic bus(logic wr, logic [9:0] a, logic [7:0] d, logic [3:0] be);
      @(posedge clk);
      address <= a;
      writedata <= {24'h0, d};
      byteenable <= be;
      write <= wr;
      read <= ~wr;
      // sampled at the rising edge; only the watchdog ends a stuck wait
      do begin
         @(posedge clk);
      end while (waitrequest !== 1'b0);
      rd = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask
   // spacing of divided channel seven ticks, second to third pulse
   task automatic ch7_gap(output int gap);
      int k, n, t0;
      k = 0;
      n = 0;
      t0 = 0;
      gap = -1;
      while (k < 3 && n < 4000) begin
         @(negedge clk);
         n++;
         if (ch7Tick === 1'b1) begin
            k++;
            if (k == 2) t0 = n;
            if (k == 3) gap = n - t0;
         end
      end
   endtask
   // ==========================================================
   // main sequence
   initial begin
      {read, write, address, writedata, byteenable} = '0;
      {chSourceSel, statusIn, ca, cb} = '0;
      slow = 1'b0;
      reset = 1'b1;
      void'($urandom(62241));
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      bus(1'b0, CH7_DIV_ADDR, 8'h00, 4'hf);
      check("ch7 reset", rd, 32'h0000_0005);
      bus(1'b0, ROUTE_ADDR, 8'h00, 4'hf);
      check("route reset", rd, 32'h0000_000a);
      bus(1'b0, 10'h3fc, 8'h00, 4'hf);
      check("unmapped", rd, 32'h0000_0000);
      bus(1'b1, CH7_DIV_ADDR, 8'h7e, 4'h0);
      bus(1'b0, CH7_DIV_ADDR, 8'h00, 4'hf);
      check("masked write", rd, 32'h0000_0005);
      bus(1'b1, STATE_ADDR, 8'hff, 4'h1);
      bus(1'b0, STATE_ADDR, 8'h00, 4'hf);
      check("state read-only", rd, 32'h0000_0000);
      $display("test registers done");
      // divider ratio over every source, bypass and the top code
      for (int i = 0; i < 8; i++) begin
         code = (i == 4) ? 8'h00 : (i == 5) ? 8'hff : 8'($urandom_range(1, 255));
         bus(1'b1, CH7_DIV_ADDR, code, 4'h1);
         bus(1'b0, CH7_DIV_ADDR, 8'h00, 4'hf);
         check("ch7 readback", rd, {24'h0, code});
         chSourceSel <= 2'(i);
         slow <= i[0];
         ch7_gap(g);
         check("ch7 gap", g, ch7_exp(2'(i), code) * (i[0] ? 2 : 1));
      end
      slow <= 1'b0;
      $display("test channel divider done");
      // status pin clocks, both pre-divider codes, both pin selections
      for (int j = 0; j < 4; j++) begin
         p1 = (j & 2) ? 2'h2 : 2'h1;
         p2 = (j & 1) ? 2'h1 : 2'h2;
         s0 = 2'(j & 1);
         ca <= 8'h00;
         cb <= 8'h00;
         // all dividers off first: a counter above a new code would wrap
         bus(1'b1, ROUTE_ADDR, ROUTE_RST, 4'h1);
         ca <= 8'($urandom_range(1, 7));
         cb <= 8'($urandom_range(1, 7));
         bus(1'b1, ROUTE_ADDR, {p2, p1, 1'b0, ~s0[0], s0}, 4'h1);
         repeat (200) @(posedge clk);
         check("pin0 half", hp0, s0[0] ? half_exp(p2, cb) : half_exp(p1, ca));
         check("pin1 half", hp1, s0[0] ? half_exp(p1, ca) : half_exp(p2, cb));
      end
      $display("test pin clocks done");
      // pre-divider off, then cmos_div_a code zero: pins stay quiet
      bus(1'b1, ROUTE_ADDR, 8'h01, 4'h1);
      repeat (20) @(posedge clk);
      g = e0 + e1;
      repeat (100) @(posedge clk);
      check("prediv off edges", e0 + e1, g);
      ca <= 8'h00;
      bus(1'b1, ROUTE_ADDR, 8'h10, 4'h1);
      repeat (20) @(posedge clk);
      g = e0;
      repeat (100) @(posedge clk);
      check("div a off edges", e0, g);
      // pin0 disabled while its clock runs, pin1 in status mode
      ca <= 8'h02;
      statusIn <= 2'($urandom);
      bus(1'b1, ROUTE_ADDR, 8'h5b, 4'h1);
      repeat (20) @(posedge clk);
      g = e0;
      repeat (100) @(posedge clk);
      check("off edges", e0, g);
      check("oe", 32'(statPinOe), 32'h0000_0002);
      check("status", 32'(statPin), 32'({statusIn[1], 1'b0}));
      bus(1'b0, STATE_ADDR, 8'h00, 4'hf);
      check("state pins", 32'(rd[3:2]), 32'({statusIn[1], 1'b0}));
      $display("test pin modes done");
      summarize();
   end
endmodule // tb_odsc_top
`default_nettype wire
